// [src/usi2c_regs.svh]
/*
 * Register indices, byte addresses, field positions, reset values and timing counts
 * of the simple I2C mode control block.
 * Assumes a 32-bit AXI4-Lite bus with one aligned word for each register.
 */
`ifndef USI2C_REGS_SVH
`define USI2C_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define USI2C_IDX_SM2 12'h376
`define USI2C_IDX_SM 12'h377
`define USI2C_IDX_SC1 12'h37D
`define USI2C_IDX_IRQ_STAT 12'h380
`define USI2C_IDX_IRQ_EN 12'h381
`define USI2C_IDX_IRQ_CLR 12'h382
`define USI2C_ADDR_W 14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define USI2C_RST_SC1 8'h02
`define USI2C_RST_SM 8'h00
`define USI2C_RST_SM2 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USI2C_SC1_TE 0
`define USI2C_SC1_TI 1
`define USI2C_SC1_RE 2
`define USI2C_SC1_RI 3
`define USI2C_SC1_IRS 4
`define USI2C_SM_I2C_MODE_SELECT 0
`define USI2C_SM_ABC 1
`define USI2C_SM_BBS 2
`define USI2C_SM_SCL_LOW_SYNC_OUTPUT_ENABLE 3
`define USI2C_SM_TOP 7
`define USI2C_SM2_I2C_MODE_SELECT_TWO 0
`define USI2C_SM2_SCL_WAIT_OUTPUT_TWO 5
`define USI2C_SM2_START_STOP_TIMING_CONTROL 7
`define USI2C_IRQ_START 0
`define USI2C_IRQ_STOP 1
`define USI2C_IRQ_C15 2
`define USI2C_IRQ_C16 3
`define USI2C_IRQ_TX 4
`define USI2C_IRQ_N 5

// ----------------------------------------------------------------
// Codes and timing counts
// ----------------------------------------------------------------
`define USI2C_DMA_SEL_ACK 4'hD
`define USI2C_COND_MIN_CYC 6

`endif

// [src/usi2c_pkg.sv]
/*
 * Shared types of the simple I2C mode control block.
 * Assumes the constants header is compiled alongside.
 */
package usi2c_pkg;
    typedef logic [7:0] usi2c_byte_t;
    typedef enum logic [1:0] {
        USI2C_OKAY = 2'h0,
        USI2C_SLVERR = 2'h2
    } usi2c_resp_e;
endpackage : usi2c_pkg

// [src/usi2c_sync.sv]
/*
 * Three-stage synchroniser for one pin; output follows once stages two and three agree.
 * Assumes the input is asynchronous to aclk.
 */
`timescale 1ns/1ps
module usi2c_sync import usi2c_pkg::*; #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic aclk, // Main clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic pin_i, // Raw pin level
    output logic level_o // Filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
            end
        end
    end
endmodule : usi2c_sync

// [src/usi2c_cond_det.sv]
/*
 * Start and stop condition detector with optional setup/hold qualification.
 * Assumes SCL and SDA are already synchronised to aclk.
 */
`timescale 1ns/1ps
`include "usi2c_regs.svh"
module usi2c_cond_det import usi2c_pkg::*; #(
    parameter int MIN_CYC = `USI2C_COND_MIN_CYC
) (
    input wire logic aclk, // Main clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic scl, // Synchronised SCL
    input wire logic sda, // Synchronised SDA
    input wire logic timing_en, // Setup/hold qualification on
    output logic start_o, // Start seen, one cycle
    output logic stop_o // Stop seen, one cycle
);
    localparam int CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] CMAX = CW'(MIN_CYC);

    logic scl_d_reg;
    logic sda_d_reg;
    logic [CW-1:0] setup_reg;
    logic [CW-1:0] hold_reg;
    logic pend_reg;
    logic pend_stop_reg;

    wire scl_steady = scl & scl_d_reg;
    wire sda_edge = scl_steady & (sda != sda_d_reg);
    wire setup_ok = (setup_reg >= CMAX);
    wire pend_abort = pend_reg & (!scl | (sda != sda_d_reg));
    wire hold_done = pend_reg & !pend_abort & (hold_reg == CMAX - CW'(1));
    wire fire_now = sda_edge & !timing_en;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            setup_reg <= '0;
            hold_reg <= '0;
            pend_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            start_o <= 1'b0;
            stop_o <= 1'b0;
        end else begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
            if (scl_steady && sda == sda_d_reg && !setup_ok) begin
                setup_reg <= setup_reg + CW'(1);
            end else if (!(scl_steady && sda == sda_d_reg)) begin
                setup_reg <= '0;
            end
            if (sda_edge && timing_en && setup_ok) begin
                pend_reg <= 1'b1;
                pend_stop_reg <= sda;
                hold_reg <= '0;
            end else if (pend_abort || hold_done) begin
                pend_reg <= 1'b0;
            end else if (pend_reg) begin
                hold_reg <= hold_reg + CW'(1);
            end
            start_o <= (fire_now & !sda) | (hold_done & !pend_stop_reg);
            stop_o <= (fire_now & sda) | (hold_done & pend_stop_reg);
        end
    end

    AST_START_LEVELS: assert property (@(posedge aclk) disable iff (!aresetn)
        start_o |-> $past(scl) && !$past(sda))
        else $error("start reported without SDA low under SCL high");
    AST_QUALIFIED_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (start_o || stop_o) && $past(timing_en, 2) && $past(timing_en) |->
            $past(scl, 2) && $past(scl))
        else $error("qualified condition reported without SCL held high");
    COV_START: cover property (@(posedge aclk) disable iff (!aresetn) start_o && timing_en);
endmodule : usi2c_cond_det

// [src/usi2c_ctrl.sv]
/*
 * Control and status registers of a UART channel run as a simple I2C interface,
 * with an AXI4-Lite slave, bus busy tracking, cause remapping and SCL pin control.
 * Assumes the UART core gives one-cycle event pulses on aclk; SCL/SDA are raw pins.
 */
`timescale 1ns/1ps
`include "usi2c_regs.svh"
module usi2c_ctrl import usi2c_pkg::*; #(
    parameter int COND_MIN_CYC = `USI2C_COND_MIN_CYC
) (
    input wire logic aclk, // Main clock, 50 MHz
    input wire logic aresetn, // Synchronous reset, low
    input wire logic [`USI2C_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [`USI2C_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic scl_i, // SCL pin level
    input wire logic sda_i, // SDA pin level
    input wire logic serial_io_active, // Serial function owns pins
    input wire logic uart_clk, // Transfer clock from UART core
    input wire logic tx_buf_written, // Transmit buffer loaded
    input wire logic tx_buf_moved, // Transmit buffer to shift register
    input wire logic tx_reg_empty_evt, // Transmit register went empty
    input wire logic rx_buf_read, // Receive buffer read
    input wire logic rx_last_rise, // Rise of last receive clock
    input wire logic rx_last_fall, // Fall of last receive clock
    input wire logic tx_last_rise, // Rise of last transmit clock
    input wire logic ack_seen, // ACK detected
    input wire logic nack_seen, // NACK detected
    input wire logic arb_bit_evt, // Arbitration check, per bit
    input wire logic arb_byte_evt, // Arbitration check, per byte
    input wire logic [3:0] dma_cause_sel, // DMA request cause selector
    output logic scl_o, // SCL drive value
    output logic scl_oe, // SCL drive enable
    output logic irq, // Interrupt, level
    output logic int_cause15, // Cause 15 pulse
    output logic int_cause16, // Cause 16 pulse
    output logic tx_irq_req, // Transmit interrupt pulse
    output logic dma_req, // DMA request pulse
    output logic rx_buf_load, // Shift to receive buffer pulse
    output logic arb_lost_update, // Arbitration flag update pulse
    output logic start_seen, // Start condition pulse
    output logic stop_seen, // Stop condition pulse
    output usi2c_byte_t sc1_o, // Serial control 1 contents
    output usi2c_byte_t sm_o, // Special mode contents
    output usi2c_byte_t sm2_o // Special mode 2 contents
);
    // ----------------------------------------------------------------
    // Pin sampling and condition detection
    // ----------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic start_evt;
    logic stop_evt;

    usi2c_sync #(.RST_VAL(1'b1)) u_scl_sync (
        .aclk(aclk), .aresetn(aresetn), .pin_i(scl_i), .level_o(scl_s));
    usi2c_sync #(.RST_VAL(1'b1)) u_sda_sync (
        .aclk(aclk), .aresetn(aresetn), .pin_i(sda_i), .level_o(sda_s));
    usi2c_cond_det #(.MIN_CYC(COND_MIN_CYC)) u_cond (
        .aclk(aclk), .aresetn(aresetn), .scl(scl_s), .sda(sda_s),
        .timing_en(sm2_o[`USI2C_SM2_START_STOP_TIMING_CONTROL]), .start_o(start_evt), .stop_o(stop_evt));

    // ----------------------------------------------------------------
    // Bus slave handshake
    // ----------------------------------------------------------------
    logic aw_have_reg;
    logic w_have_reg;
    logic [`USI2C_ADDR_W-1:0] waddr_reg;
    logic [7:0] wbyte_reg;
    logic wlane_reg;
    logic [4:0] irq_stat_reg;
    logic [4:0] irq_en_reg;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_wr = aw_have_reg & w_have_reg & !s_axi_bvalid;
    wire aw_have_next = (aw_have_reg | aw_take) & !do_wr;
    wire w_have_next = (w_have_reg | w_take) & !do_wr;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rvalid_next = ar_take | (s_axi_rvalid & !s_axi_rready);

    function automatic logic [`USI2C_ADDR_W-1:0] idx_addr(input logic [11:0] idx);
        idx_addr = {idx, 2'b00};
    endfunction : idx_addr

    function automatic logic mapped(input logic [`USI2C_ADDR_W-1:0] a);
        mapped = a == idx_addr(`USI2C_IDX_SC1) || a == idx_addr(`USI2C_IDX_SM)
            || a == idx_addr(`USI2C_IDX_SM2) || a == idx_addr(`USI2C_IDX_IRQ_STAT)
            || a == idx_addr(`USI2C_IDX_IRQ_EN) || a == idx_addr(`USI2C_IDX_IRQ_CLR);
    endfunction : mapped

    wire wr_en = do_wr & wlane_reg;
    wire wr_sc1 = wr_en & (waddr_reg == idx_addr(`USI2C_IDX_SC1));
    wire wr_sm = wr_en & (waddr_reg == idx_addr(`USI2C_IDX_SM));
    wire wr_sm2 = wr_en & (waddr_reg == idx_addr(`USI2C_IDX_SM2));
    wire wr_ien = wr_en & (waddr_reg == idx_addr(`USI2C_IDX_IRQ_EN));
    wire wr_iclr = wr_en & (waddr_reg == idx_addr(`USI2C_IDX_IRQ_CLR));

    // Clear register is write-only and reads as zero
    wire [7:0] rd_byte =
        (s_axi_araddr == idx_addr(`USI2C_IDX_SC1)) ? sc1_o :
        (s_axi_araddr == idx_addr(`USI2C_IDX_SM)) ? {1'b0, sm_o[6:0]} :
        (s_axi_araddr == idx_addr(`USI2C_IDX_SM2)) ? sm2_o :
        (s_axi_araddr == idx_addr(`USI2C_IDX_IRQ_STAT)) ? {3'h0, irq_stat_reg} :
        (s_axi_araddr == idx_addr(`USI2C_IDX_IRQ_EN)) ? {3'h0, irq_en_reg} : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= USI2C_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= USI2C_OKAY;
            waddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            s_axi_awready <= !aw_have_next;
            s_axi_wready <= !w_have_next;
            if (aw_take) begin
                waddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wbyte_reg <= s_axi_wdata[7:0];
                wlane_reg <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(waddr_reg) ? USI2C_OKAY : USI2C_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_rvalid <= rvalid_next;
            s_axi_arready <= !rvalid_next;
            if (ar_take) begin
                s_axi_rdata <= {24'h0, rd_byte};
                s_axi_rresp <= mapped(s_axi_araddr) ? USI2C_OKAY : USI2C_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Event remapping
    // ----------------------------------------------------------------
    wire mode_i2c = sm_o[`USI2C_SM_I2C_MODE_SELECT];
    wire mode_two = sm2_o[`USI2C_SM2_I2C_MODE_SELECT_TWO];
    wire both_modes = mode_i2c & mode_two;
    wire rx_load_evt = mode_two ? rx_last_fall : rx_last_rise;
    wire c15_evt = mode_two ? tx_last_rise : nack_seen;
    wire c16_evt = mode_two ? rx_last_fall : ack_seen;
    wire dma_evt = (dma_cause_sel == `USI2C_DMA_SEL_ACK) & (mode_two ? rx_last_fall : ack_seen);
    wire tx_sel_evt = sc1_o[`USI2C_SC1_IRS] ? tx_reg_empty_evt : tx_buf_moved;
    wire tx_evt = both_modes ? c15_evt : tx_sel_evt;
    wire arb_evt = sm_o[`USI2C_SM_ABC] ? arb_byte_evt : arb_bit_evt;
    wire [4:0] irq_evt = {tx_evt, c16_evt, c15_evt, stop_evt, start_evt};

    // ----------------------------------------------------------------
    // Registers and flags
    // ----------------------------------------------------------------
    // Set beats clear on every hardware flag so no event is lost
    wire ti_next = tx_buf_moved | (sc1_o[`USI2C_SC1_TI] & !tx_buf_written);
    wire ri_next = rx_load_evt | (sc1_o[`USI2C_SC1_RI] & !rx_buf_read);
    wire bbs_next = start_evt | (sm_o[`USI2C_SM_BBS] & !stop_evt
        & !(wr_sm & !wbyte_reg[`USI2C_SM_BBS]));
    wire [7:0] sc1_sw = wr_sc1 ? wbyte_reg : sc1_o;
    wire [7:0] sm_sw = wr_sm ? wbyte_reg : sm_o;
    wire [7:0] sc1_next = {sc1_sw[7:4], ri_next, sc1_sw[2], ti_next, sc1_sw[0]};
    wire [7:0] sm_next = {1'b0, sm_sw[6:3], bbs_next, sm_sw[1:0]};
    wire [4:0] stat_next = irq_evt | (irq_stat_reg & ~(wr_iclr ? wbyte_reg[4:0] : 5'h00));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sc1_o <= `USI2C_RST_SC1;
            sm_o <= `USI2C_RST_SM;
            sm2_o <= `USI2C_RST_SM2;
            irq_stat_reg <= 5'h00;
            irq_en_reg <= 5'h00;
            irq <= 1'b0;
        end else begin
            sc1_o <= sc1_next;
            sm_o <= sm_next;
            if (wr_sm2) begin
                sm2_o <= wbyte_reg;
            end
            if (wr_ien) begin
                irq_en_reg <= wbyte_reg[4:0];
            end
            irq_stat_reg <= stat_next;
            irq <= |(stat_next & (wr_ien ? wbyte_reg[4:0] : irq_en_reg));
        end
    end

    // ----------------------------------------------------------------
    // Event outputs and SCL drive
    // ----------------------------------------------------------------
    wire i2c_active = mode_i2c & serial_io_active;
    // Low sync only tracks the bus when port logic owns the pin
    wire scl_low_sync_output_enable_drive = !serial_io_active & sm_o[`USI2C_SM_SCL_LOW_SYNC_OUTPUT_ENABLE] & !scl_s;
    wire ser_drive = sm2_o[`USI2C_SM2_SCL_WAIT_OUTPUT_TWO] | !uart_clk;
    wire scl_oe_next = i2c_active ? ser_drive : scl_low_sync_output_enable_drive;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_o <= 1'b0;
            scl_oe <= 1'b0;
            int_cause15 <= 1'b0;
            int_cause16 <= 1'b0;
            tx_irq_req <= 1'b0;
            dma_req <= 1'b0;
            rx_buf_load <= 1'b0;
            arb_lost_update <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            scl_oe <= scl_oe_next;
            int_cause15 <= c15_evt;
            int_cause16 <= c16_evt;
            tx_irq_req <= tx_evt;
            dma_req <= dma_evt;
            rx_buf_load <= rx_load_evt;
            arb_lost_update <= arb_evt;
            start_seen <= start_evt;
            stop_seen <= stop_evt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_RESET_SC1: assert property (@(posedge aclk)
        $past(!aresetn) && aresetn |-> sc1_o == 8'h02 && sm_o == 8'h00)
        else $error("control registers off their reset values");
    AST_BUSY_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        start_evt |=> sm_o[2] && start_seen)
        else $error("busy flag not set by start");
    AST_BUSY_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_evt && !start_evt |=> !sm_o[2] ##1 !sm_o[2] || $past(start_evt))
        else $error("busy flag not cleared by stop");
    AST_TOP_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && s_axi_araddr == 14'hDDC |=> s_axi_rvalid && !s_axi_rdata[7])
        else $error("special mode top bit read non-zero");
    AST_RX_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        sm2_o[0] && rx_last_fall |=> rx_buf_load && sc1_o[3])
        else $error("receive buffer load on wrong edge");
    AST_CAUSE15: assert property (@(posedge aclk) disable iff (!aresetn)
        !sm2_o[0] && nack_seen && !tx_last_rise |=> int_cause15)
        else $error("cause 15 missed NACK");
    AST_RX_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
        !sm2_o[0] && rx_last_fall && !ack_seen |=> !int_cause16)
        else $error("receive interrupt on fall in mode two off");
    AST_DMA: assert property (@(posedge aclk) disable iff (!aresetn)
        dma_cause_sel == 4'hD && !sm2_o[0] && ack_seen |=> dma_req)
        else $error("DMA request missed ACK");
    AST_TX_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
        !(sm_o[0] && sm2_o[0]) && sc1_o[4] && tx_buf_moved && !tx_reg_empty_evt
            |=> !tx_irq_req)
        else $error("transmit interrupt from unselected source");
    AST_ARB: assert property (@(posedge aclk) disable iff (!aresetn)
        sm_o[1] && arb_bit_evt && !arb_byte_evt |=> !arb_lost_update)
        else $error("arbitration update per bit in byte policy");
    AST_SCL_WAIT_OUTPUT_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
        sm_o[0] && serial_io_active && sm2_o[5] |=> scl_oe && !scl_o)
        else $error("SCL not forced low");
    AST_SCL_LOW_SYNC_OUTPUT_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        serial_io_active && !sm_o[0] && sm_o[3] |=> !scl_oe)
        else $error("low sync active under serial control");
    COV_START_STOP: cover property (@(posedge aclk) disable iff (!aresetn)
        start_evt ##[1:1000] stop_evt);
    COV_MODE2_RX: cover property (@(posedge aclk) disable iff (!aresetn)
        sm2_o[0] && rx_last_fall);
    COV_DMA: cover property (@(posedge aclk) disable iff (!aresetn) dma_req);
    COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule : usi2c_ctrl

// [tb/usi2c_bus_model.sv]
/*
 * Other bus party on SCL/SDA: makes start and stop conditions.
 * Assumes pull-ups on both lines and that the block only pulls SCL low.
 */
`timescale 1ns/1ps
module usi2c_bus_model (
    input wire logic scl_oe, // Block pulls SCL low
    input wire logic scl_o, // Block drive value
    output logic scl_i, // SCL wire level
    output logic sda_i // SDA wire level
);
    logic scl_m = 1'b1;
    logic sda_m = 1'b1;
    // Wired-AND with pull-up
    assign scl_i = scl_m & ~(scl_oe & ~scl_o);
    assign sda_i = sda_m;
    // SDA edge while SCL high, half a 160 ns link period apart
    task cond(input logic to_stop);
        sda_m = to_stop ? 1'b0 : 1'b1;
        #80 scl_m = 1'b1;
        #80 sda_m = to_stop;
        #80;
    endtask : cond
endmodule : usi2c_bus_model

// [tb/tb.sv]
/*
 * Register and event bench for the simple I2C control block.
 * Assumes the bus model drives the pins; events are driven as aclk pulses.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, serial_io_active = 0, uart_clk = 1;
    logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, dma_cause_sel = 4'hD;
    logic [10:0] ev = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic scl_i, sda_i, scl_o, scl_oe, irq, int_cause15, int_cause16, tx_irq_req, dma_req;
    logic rx_buf_load, arb_lost_update, start_seen, stop_seen;
    logic [7:0] sc1_o, sm_o, sm2_o;
    logic [31:0] d;
    int err_total = 0, check_count = 0;
    wire logic tx_reg_empty_evt = ev[0], arb_byte_evt = ev[1], arb_bit_evt = ev[2];
    wire logic tx_last_rise = ev[3], rx_last_fall = ev[4], nack_seen = ev[5];
    wire logic tx_buf_written = ev[6], tx_buf_moved = ev[7], rx_buf_read = ev[8];
    wire logic rx_last_rise = ev[9], ack_seen = ev[10];
    usi2c_ctrl #(.COND_MIN_CYC(3)) dut_u (.*);
    usi2c_bus_model bm_u (.scl_oe(scl_oe), .scl_o(scl_o), .scl_i(scl_i), .sda_i(sda_i));
    // Condition pulses last one cycle, so count them instead of chasing them
    int n_start = 0, n_stop = 0;
    always @(posedge aclk) begin
        if (start_seen) n_start++;
        if (stop_seen) n_stop++;
    end
    initial begin
        forever #10 aclk = ~aclk;
    end
    task wr(input logic [13:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!((!s_axi_awvalid || s_axi_awready) && (!s_axi_wvalid || s_axi_wready)));
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask : wr
    task rd(input logic [13:0] a, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0; s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        s_axi_rready <= 0;
    endtask : rd
    // One-cycle event, then look at outputs settled after the answer edge
    task p(input int i);
        @(posedge aclk); ev <= 11'h1 << i;
        @(posedge aclk); ev <= 0;
        #1;
    endtask : p
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        #300000 err_total++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(14'hDF4, d); `CHK("sc1 rst", 32'h02, d)
        rd(14'hDDC, d); `CHK("sm rst", 32'h00, d)
        rd(14'h0000, d); `CHK("unmapped", 2'h2, s_axi_rresp)
        wr(14'h0000, 32'h0); `CHK("wr unmapped", 2'h2, s_axi_bresp)
        wr(14'hDF4, 32'h3F); rd(14'hDF4, d); `CHK("sc1 ro", 32'h37, d)
        p(0); `CHK("tx src reg", 1'b1, tx_irq_req)
        wr(14'hDD8, 32'h80);
        wr(14'hDDC, 32'h8F); rd(14'hDDC, d); `CHK("sm top", 32'h0B, d)
        p(1); `CHK("arb byte", 1'b1, arb_lost_update)
        p(2); `CHK("arb bit", 1'b0, arb_lost_update)
        wr(14'hDDC, 32'h09); p(2); `CHK("arb each bit", 1'b1, arb_lost_update)
        p(5); `CHK("nack c15", 1'b1, int_cause15)
        serial_io_active <= 1; wr(14'hDD8, 32'hA0); #1;
        `CHK("scl_wait_output_two", 2'b10, {scl_oe, scl_o})
        wr(14'hDD8, 32'h81); `CHK("sm2 port", 8'h81, sm2_o)
        p(3); `CHK("c15 tx", 1'b1, int_cause15)
        p(4); `CHK("rx fall", 4'hF, {int_cause16, rx_buf_load, dma_req, 1'b1})
        p(6); rd(14'hDF4, d); `CHK("sc1 flags", 32'h3D, d)
        `CHK("sc1 port", 8'h3D, sc1_o)
        serial_io_active <= 0; wr(14'hE04, 32'h01);
        bm_u.cond(0); repeat (8) @(posedge aclk);
        rd(14'hDDC, d); `CHK("busy set", 32'h0D, d)
        `CHK("sm port", 8'h0D, sm_o)
        `CHK("starts", 1, n_start)
        `CHK("irq on", 1'b1, irq)
        wr(14'hE08, 32'h01); #1; `CHK("irq off", 1'b0, irq)
        bm_u.cond(1); repeat (8) @(posedge aclk);
        rd(14'hDDC, d); `CHK("busy clr", 32'h09, d)
        rd(14'hE00, d); `CHK("irq stat", 32'h1E, d)
        `CHK("stops", 1, n_stop)
        wr(14'hDD8, 32'h80); p(9); `CHK("rx rise", 1'b1, rx_buf_load)
        p(10); `CHK("ack", 3'h6, {int_cause16, dma_req, rx_buf_load})
        end_of_test();
    end
endmodule : tb
